// ### core/twrp_defines.svh
// Offsets, field positions, reset values and frame counts of the three-wire register port
`ifndef TWRP_DEFINES_SVH
`define TWRP_DEFINES_SVH

// Frame layout, most significant bit first in every field
`define TWRP_ADDR_BITS 6
`define TWRP_CODE_BITS 2
`define TWRP_DATA_BITS 8
`define TWRP_HEADER_LAST 5'h07
`define TWRP_FRAME_LAST 5'h0f

// Direction codes
`define TWRP_CODE_WRITE 2'h1
`define TWRP_CODE_READ 2'h2

// Register offsets
`define TWRP_OFFS_BATMON_CTRL 6'h11
`define TWRP_OFFS_BATMON_TRIM 6'h12
`define TWRP_OFFS_SUPPLY_ENABLE 6'h16
`define TWRP_OFFS_CHARGER_STATUS 6'h20

// Field positions
`define TWRP_BIT_BATMON_EN 0
`define TWRP_TRIM_MSB 4
`define TWRP_BIT_ADAPTER_PRESENT 0
`define TWRP_BIT_AUDIO 0
`define TWRP_BIT_VIBRATOR 1
`define TWRP_BIT_RECEIVE_ONE 2
`define TWRP_BIT_TRANSMIT 3
`define TWRP_BIT_RECEIVE_TWO 4
`define TWRP_BIT_RADIO_OPTION 5
`define TWRP_BIT_OPTION 6
`define TWRP_BIT_REFERENCE 7

// Reset values and the read value of unmapped offsets
`define TWRP_RST_BATMON_EN 1'h0
`define TWRP_RST_BATMON_TRIM 5'h00
`define TWRP_RST_SUPPLY_ENABLE 8'h00
`define TWRP_UNMAPPED_READ 8'h00

`endif

// ### core/twrp_pkg.sv
// Types shared by the three-wire register port
package twrp_pkg;
  // Frame sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HEADER,
    ST_WRITE,
    ST_READ,
    ST_IGNORE,
    ST_DONE
  } twrp_state_t;
endpackage : twrp_pkg

// ### core/twrp_sync.sv
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module twrp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic externalResetN,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stageOne;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk or negedge externalResetN)
  begin
    if (!externalResetN)
    begin
      stageOne <= '0;
      syncOut <= '0;
    end
    else if (sys_rst)
    begin
      stageOne <= '0;
      syncOut <= '0;
    end
    else
    begin
      stageOne <= asyncIn;
      syncOut <= stageOne;
    end
  end
endmodule : twrp_sync

// ### core/twrp_register_port.sv
// Three-wire serial register port with battery monitor, supply enable and charger status registers
`timescale 1ns/1ps
`include "twrp_defines.svh"
module twrp_register_port (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic externalResetN,
  input wire logic selectIn,
  input wire logic serialClockIn,
  input wire logic dataIn,
  output logic dataOut,
  output logic dataOe,
  input wire logic adapterDetectIn,
  output logic adapterPresent,
  output logic chargerEvent,
  output logic batteryMonitorEnable,
  output logic [4:0] batteryMonitorTrim,
  output logic audioRegulatorEnable,
  output logic vibratorRegulatorEnable,
  output logic receiveOneRegulatorEnable,
  output logic transmitRegulatorEnable,
  output logic receiveTwoRegulatorEnable,
  output logic radioOptionRegulatorEnable,
  output logic optionRegulatorEnable,
  output logic referenceOutputEnable
);
  twrp_pkg::twrp_state_t state;
  logic selSync;
  logic clkSync;
  logic dataSync;
  logic adapterSync;
  logic clkPrev;
  logic fallEdge;
  logic riseEdge;
  logic [4:0] bitCount;
  logic [7:0] headerShift;
  logic [7:0] writeShift;
  logic [7:0] readShift;
  logic [1:0] next_code;
  logic [5:0] next_addr;
  logic [7:0] next_byte;
  logic writeStrobe;
  logic [5:0] writeAddr;
  logic [7:0] writeData;
  logic [7:0] supplyEnable;

  // Select, serial clock, data and adapter detect pins pass two flops before any logic looks at them
  twrp_sync #(
    .WIDTH(4)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .externalResetN(externalResetN),
    .asyncIn({selectIn, serialClockIn, dataIn, adapterDetectIn}),
    .syncOut({selSync, clkSync, dataSync, adapterSync})
  );

  // Previous serial clock level for edge finding
  always_ff @(posedge ref_clk or negedge externalResetN)
  begin
    if (!externalResetN)
      clkPrev <= 1'h0;
    else if (sys_rst)
      clkPrev <= 1'h0;
    else
      clkPrev <= clkSync;
  end

  // Edges only count while select is high
  assign fallEdge = selSync & clkPrev & ~clkSync;
  assign riseEdge = selSync & ~clkPrev & clkSync;

  // Header fields after the last header bit arrives; address precedes code
  assign next_addr = headerShift[6:1];
  assign next_code = {headerShift[0], dataSync};
  assign next_byte = {writeShift[6:0], dataSync};

  // Read-back value for a register offset; unmapped offsets read as zero
  function automatic logic [7:0] readValue(input logic [5:0] addr);
    logic [7:0] value;
    value = `TWRP_UNMAPPED_READ;
    unique case (addr)
      `TWRP_OFFS_BATMON_CTRL:
      begin
        value[`TWRP_BIT_BATMON_EN] = batteryMonitorEnable;
      end
      `TWRP_OFFS_BATMON_TRIM:
      begin
        value[`TWRP_TRIM_MSB:0] = batteryMonitorTrim;
      end
      `TWRP_OFFS_SUPPLY_ENABLE:
      begin
        value = supplyEnable;
      end
      `TWRP_OFFS_CHARGER_STATUS:
      begin
        value[`TWRP_BIT_ADAPTER_PRESENT] = adapterPresent;
      end
      default:
      begin
        value = `TWRP_UNMAPPED_READ;
      end
    endcase
    return value;
  endfunction : readValue

  // Frame sequencer; the external reset clears it without the clock
  always_ff @(posedge ref_clk or negedge externalResetN)
  begin
    if (!externalResetN)
    begin
      state <= twrp_pkg::ST_IDLE;
      bitCount <= 5'h00;
      headerShift <= 8'h00;
      writeShift <= 8'h00;
    end
    else if (sys_rst)
    begin
      state <= twrp_pkg::ST_IDLE;
      bitCount <= 5'h00;
      headerShift <= 8'h00;
      writeShift <= 8'h00;
    end
    else if (!selSync)
    begin
      // A partial frame is thrown away; nothing was committed yet
      state <= twrp_pkg::ST_IDLE;
      bitCount <= 5'h00;
    end
    else
    begin
      unique case (state)
        twrp_pkg::ST_IDLE:
        begin
          // Host holds the clock low at select rise, so the next fall is bit one
          state <= twrp_pkg::ST_HEADER;
          bitCount <= 5'h00;
        end
        twrp_pkg::ST_HEADER:
        begin
          if (fallEdge)
          begin
            headerShift <= {headerShift[6:0], dataSync};
            bitCount <= bitCount + 5'h01;
            if (bitCount == `TWRP_HEADER_LAST)
            begin
              if (next_code == `TWRP_CODE_WRITE)
                state <= twrp_pkg::ST_WRITE;
              else if (next_code == `TWRP_CODE_READ)
                state <= twrp_pkg::ST_READ;
              else
                state <= twrp_pkg::ST_IGNORE;
            end
          end
        end
        twrp_pkg::ST_WRITE:
        begin
          if (fallEdge)
          begin
            writeShift <= next_byte;
            bitCount <= bitCount + 5'h01;
            if (bitCount == `TWRP_FRAME_LAST)
              state <= twrp_pkg::ST_DONE;
          end
        end
        twrp_pkg::ST_READ,
        twrp_pkg::ST_IGNORE:
        begin
          if (fallEdge)
          begin
            bitCount <= bitCount + 5'h01;
            if (bitCount == `TWRP_FRAME_LAST)
              state <= twrp_pkg::ST_DONE;
          end
        end
        twrp_pkg::ST_DONE:
        begin
          // Extra clocks are ignored until select drops
          bitCount <= bitCount;
        end
      endcase
    end
  end

  // Write commit happens only on a whole frame with the write code
  always_ff @(posedge ref_clk or negedge externalResetN)
  begin
    if (!externalResetN)
    begin
      writeStrobe <= 1'h0;
      writeAddr <= 6'h00;
      writeData <= 8'h00;
    end
    else if (sys_rst)
    begin
      writeStrobe <= 1'h0;
      writeAddr <= 6'h00;
      writeData <= 8'h00;
    end
    else
    begin
      writeStrobe <= 1'h0;
      if (selSync && fallEdge && state == twrp_pkg::ST_WRITE &&
          bitCount == `TWRP_FRAME_LAST)
      begin
        writeStrobe <= 1'h1;
        writeAddr <= headerShift[7:2];
        writeData <= next_byte;
      end
    end
  end

  // Read data launch on rising edges; the line is driven only in the data phase
  always_ff @(posedge ref_clk or negedge externalResetN)
  begin
    if (!externalResetN)
    begin
      dataOe <= 1'h0;
      dataOut <= 1'h0;
      readShift <= 8'h00;
    end
    else if (sys_rst)
    begin
      dataOe <= 1'h0;
      dataOut <= 1'h0;
      readShift <= 8'h00;
    end
    else if (!selSync)
    begin
      dataOe <= 1'h0;
      dataOut <= 1'h0;
    end
    else if (state == twrp_pkg::ST_HEADER && fallEdge &&
             bitCount == `TWRP_HEADER_LAST)
    begin
      // Snapshot the register at header end so the byte cannot tear mid-read
      readShift <= readValue(next_addr);
    end
    else if (state == twrp_pkg::ST_READ && riseEdge)
    begin
      dataOe <= 1'h1;
      dataOut <= readShift[7];
      readShift <= {readShift[6:0], 1'h0};
    end
    else if (state == twrp_pkg::ST_READ && fallEdge &&
             bitCount == `TWRP_FRAME_LAST)
    begin
      // Release after the host has taken the last bit
      dataOe <= 1'h0;
      dataOut <= 1'h0;
    end
    else if (state != twrp_pkg::ST_READ)
    begin
      dataOe <= 1'h0;
      dataOut <= 1'h0;
    end
  end

  // Battery monitor enable and trim registers
  always_ff @(posedge ref_clk or negedge externalResetN)
  begin
    if (!externalResetN)
    begin
      batteryMonitorEnable <= `TWRP_RST_BATMON_EN;
      batteryMonitorTrim <= `TWRP_RST_BATMON_TRIM;
    end
    else if (sys_rst)
    begin
      batteryMonitorEnable <= `TWRP_RST_BATMON_EN;
      batteryMonitorTrim <= `TWRP_RST_BATMON_TRIM;
    end
    else if (writeStrobe)
    begin
      if (writeAddr == `TWRP_OFFS_BATMON_CTRL)
        batteryMonitorEnable <= writeData[`TWRP_BIT_BATMON_EN];
      if (writeAddr == `TWRP_OFFS_BATMON_TRIM)
        batteryMonitorTrim <= writeData[`TWRP_TRIM_MSB:0];
    end
  end

  // Serially controlled supply enables, all cleared by the external reset
  always_ff @(posedge ref_clk or negedge externalResetN)
  begin
    if (!externalResetN)
      supplyEnable <= `TWRP_RST_SUPPLY_ENABLE;
    else if (sys_rst)
      supplyEnable <= `TWRP_RST_SUPPLY_ENABLE;
    else if (writeStrobe && writeAddr == `TWRP_OFFS_SUPPLY_ENABLE)
      supplyEnable <= writeData;
  end

  // Each enable is a bit of the supply register flop
  assign audioRegulatorEnable = supplyEnable[`TWRP_BIT_AUDIO];
  assign vibratorRegulatorEnable = supplyEnable[`TWRP_BIT_VIBRATOR];
  assign receiveOneRegulatorEnable = supplyEnable[`TWRP_BIT_RECEIVE_ONE];
  assign transmitRegulatorEnable = supplyEnable[`TWRP_BIT_TRANSMIT];
  assign receiveTwoRegulatorEnable = supplyEnable[`TWRP_BIT_RECEIVE_TWO];
  assign radioOptionRegulatorEnable = supplyEnable[`TWRP_BIT_RADIO_OPTION];
  assign optionRegulatorEnable = supplyEnable[`TWRP_BIT_OPTION];
  assign referenceOutputEnable = supplyEnable[`TWRP_BIT_REFERENCE];

  // Adapter-present flag follows the comparator; any change pulses the event
  always_ff @(posedge ref_clk or negedge externalResetN)
  begin
    if (!externalResetN)
    begin
      adapterPresent <= 1'h0;
      chargerEvent <= 1'h0;
    end
    else if (sys_rst)
    begin
      adapterPresent <= 1'h0;
      chargerEvent <= 1'h0;
    end
    else
    begin
      adapterPresent <= adapterSync;
      // Comparator hysteresis is analog, so one pulse per change is enough
      chargerEvent <= adapterSync ^ adapterPresent;
    end
  end
endmodule : twrp_register_port

// ### verif/twrp_register_port_props.sv
// Pin-level checker for the three-wire register port
`timescale 1ns/1ps
module twrp_register_port_props (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic externalResetN,
  input wire logic selectIn,
  input wire logic serialClockIn,
  input wire logic adapterDetectIn,
  input wire logic dataOut,
  input wire logic dataOe,
  input wire logic adapterPresent,
  input wire logic chargerEvent,
  input wire logic batteryMonitorEnable,
  input wire logic [4:0] batteryMonitorTrim,
  input wire logic audioRegulatorEnable,
  input wire logic referenceOutputEnable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst || !externalResetN);
  // Event pulse is tied to each change of the synced flag, and the flag follows a stable pin
  evt_pulse_a: assert property (chargerEvent |=> !chargerEvent)
    else $error("event pulse longer than one cycle");
  evt_cause_a: assert property ($changed(adapterPresent) |-> chargerEvent)
    else $error("flag change without event");
  evt_only_a: assert property (chargerEvent |-> $changed(adapterPresent))
    else $error("event without flag change");
  flag_follow_a: assert property ($stable(adapterDetectIn)[*5] |-> adapterPresent == adapterDetectIn)
    else $error("adapter flag does not follow pin");
  // Data line ownership and register hold without select
  idle_release_a: assert property (!selectIn[*6] |-> !dataOe)
    else $error("data line driven without select");
  drive_start_a: assert property ($rose(dataOe) |-> selectIn && $past(serialClockIn, 2))
    else $error("drive started off a rising clock");
  bit_launch_a: assert property (dataOe && $changed(dataOut) |-> $past(serialClockIn, 2))
    else $error("read bit changed while clock low");
  regs_hold_a: assert property (!selectIn[*8] |=> $stable({batteryMonitorEnable,
    batteryMonitorTrim, audioRegulatorEnable, referenceOutputEnable}))
    else $error("register changed without select");
  // Synchronous reset clears outputs whatever the other reset does
  rst_clear_a: assert property (disable iff (1'b0) sys_rst |=> !dataOe && !batteryMonitorEnable
    && batteryMonitorTrim == 5'h00 && !audioRegulatorEnable && !referenceOutputEnable)
    else $error("outputs not cleared by reset");
endmodule : twrp_register_port_props
bind twrp_register_port twrp_register_port_props chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .externalResetN(externalResetN), .selectIn(selectIn), .serialClockIn(serialClockIn),
  .adapterDetectIn(adapterDetectIn), .dataOut(dataOut), .dataOe(dataOe),
  .adapterPresent(adapterPresent), .chargerEvent(chargerEvent),
  .batteryMonitorEnable(batteryMonitorEnable), .batteryMonitorTrim(batteryMonitorTrim),
  .audioRegulatorEnable(audioRegulatorEnable), .referenceOutputEnable(referenceOutputEnable));

// ### verif/twrp_host_model.sv
// Serial host model: drives select, clock and data, samples read data
`timescale 1ns/1ps
`include "twrp_defines.svh"
module twrp_host_model (
  input wire logic ref_clk,
  input wire logic dataOut,
  input wire logic dataOe,
  output logic selectIn,
  output logic serialClockIn,
  output logic dataIn
);
  logic hostOe, hostBit, floatBit;
  initial
  begin
    selectIn = 1'b0;
    serialClockIn = 1'b0;
    hostOe = 1'b0;
    hostBit = 1'b0;
    floatBit = 1'b0;
  end
  // A released line toggles so a stale bit never reads back by luck
  always @(posedge ref_clk) floatBit <= ~floatBit;
  assign dataIn = dataOe ? dataOut : (hostOe ? hostBit : floatBit);
  // One frame; nbits below 16 aborts it, sel low clocks with no select
  task automatic frame(input logic [5:0] a, input logic [1:0] c, input logic [7:0] d,
    input int nbits, input int half, input logic sel, output logic [7:0] rd);
    logic [15:0] w;
    w = {a, c, d};
    rd = 8'h00;
    @(negedge ref_clk);
    selectIn = sel;
    repeat (half) @(negedge ref_clk);
    for (int i = 15; i > 15 - nbits; i--)
    begin
      repeat (half) @(negedge ref_clk);
      serialClockIn = 1'b1;
      // Data moves on the rising edge, so it holds across the falling edge that takes it
      hostOe = (i > 7) || (c != `TWRP_CODE_READ);
      hostBit = w[i];
      repeat (half) @(negedge ref_clk);
      if (i < 8) rd[i] = dataIn;
      serialClockIn = 1'b0;
    end
    repeat (half) @(negedge ref_clk);
    selectIn = 1'b0;
    hostOe = 1'b0;
    // Shortened deselect gap; the port needs only a few cycles
    repeat (16) @(negedge ref_clk);
  endtask : frame
endmodule : twrp_host_model

// ### verif/twrp_register_port_tb.sv
// Self-checking testbench for the three-wire register port
`timescale 1ns/1ps
`include "twrp_defines.svh"
module twrp_register_port_tb;
  logic ref_clk, sys_rst, externalResetN, adapterDetectIn, selectIn, serialClockIn, dataIn;
  logic dataOut, dataOe, adapterPresent, chargerEvent, batteryMonitorEnable, oeSeen;
  logic [4:0] batteryMonitorTrim;
  logic [7:0] supply, rd;
  int err_count, cmp_count, evtCount;
  twrp_register_port DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .externalResetN(externalResetN), .selectIn(selectIn), .serialClockIn(serialClockIn),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .adapterDetectIn(adapterDetectIn),
    .adapterPresent(adapterPresent), .chargerEvent(chargerEvent),
    .batteryMonitorEnable(batteryMonitorEnable), .batteryMonitorTrim(batteryMonitorTrim),
    .audioRegulatorEnable(supply[0]), .vibratorRegulatorEnable(supply[1]),
    .receiveOneRegulatorEnable(supply[2]), .transmitRegulatorEnable(supply[3]),
    .receiveTwoRegulatorEnable(supply[4]), .radioOptionRegulatorEnable(supply[5]),
    .optionRegulatorEnable(supply[6]), .referenceOutputEnable(supply[7]));
  twrp_host_model host (.ref_clk(ref_clk), .dataOut(dataOut), .dataOe(dataOe),
    .selectIn(selectIn), .serialClockIn(serialClockIn), .dataIn(dataIn));
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Monitors for drive and event activity between checks
  always @(posedge ref_clk) if (dataOe) oeSeen <= 1'b1;
  always @(posedge ref_clk) if (chargerEvent) evtCount <= evtCount + 1;
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  task automatic t_write_read();
    host.frame(`TWRP_OFFS_BATMON_CTRL, `TWRP_CODE_WRITE, 8'h01, 16, 5, 1'b1, rd);
    check("monitor enable", {7'h00, batteryMonitorEnable}, 8'h01);
    host.frame(`TWRP_OFFS_BATMON_TRIM, `TWRP_CODE_WRITE, 8'hb5, 16, 50, 1'b1, rd);
    check("trim", {3'h0, batteryMonitorTrim}, 8'h15);
    host.frame(`TWRP_OFFS_SUPPLY_ENABLE, `TWRP_CODE_WRITE, 8'ha5, 16, 5, 1'b1, rd);
    check("supply", supply, 8'ha5);
    host.frame(`TWRP_OFFS_BATMON_TRIM, `TWRP_CODE_READ, 8'h00, 16, 5, 1'b1, rd);
    check("trim read", {3'h0, rd[4:0]}, 8'h15);
    host.frame(`TWRP_OFFS_SUPPLY_ENABLE, `TWRP_CODE_READ, 8'h00, 16, 50, 1'b1, rd);
    check("supply read", rd, 8'ha5);
    host.frame(`TWRP_OFFS_BATMON_CTRL, `TWRP_CODE_WRITE, 8'h00, 16, 5, 1'b1, rd);
    check("monitor off", {7'h00, batteryMonitorEnable}, 8'h00);
  endtask : t_write_read
  // Undefined codes, aborted frames and unselected clocks leave the trim alone
  task automatic t_refused();
    oeSeen = 1'b0;
    host.frame(`TWRP_OFFS_BATMON_TRIM, 2'h0, 8'h4a, 16, 5, 1'b1, rd);
    host.frame(`TWRP_OFFS_BATMON_TRIM, 2'h3, 8'h4a, 16, 5, 1'b1, rd);
    check("undefined code", {2'h0, oeSeen, batteryMonitorTrim}, 8'h15);
    host.frame(`TWRP_OFFS_BATMON_TRIM, `TWRP_CODE_WRITE, 8'h0c, 12, 5, 1'b1, rd);
    host.frame(`TWRP_OFFS_BATMON_TRIM, `TWRP_CODE_WRITE, 8'h03, 16, 5, 1'b0, rd);
    check("abort and no select", {2'h0, oeSeen, batteryMonitorTrim}, 8'h15);
    host.frame(`TWRP_OFFS_SUPPLY_ENABLE, `TWRP_CODE_READ, 8'h00, 11, 5, 1'b1, rd);
    check("released", {6'h00, oeSeen, dataOe}, 8'h02);
    host.frame(`TWRP_OFFS_SUPPLY_ENABLE, `TWRP_CODE_READ, 8'h00, 16, 5, 1'b1, rd);
    check("resent read", rd, 8'ha5);
  endtask : t_refused
  task automatic t_adapter();
    adapterDetectIn = 1'b1;
    repeat (8) @(negedge ref_clk);
    check("present", {evtCount[6:0], adapterPresent}, 8'h03);
    host.frame(`TWRP_OFFS_CHARGER_STATUS, `TWRP_CODE_WRITE, 8'h00, 16, 5, 1'b1, rd);
    host.frame(`TWRP_OFFS_CHARGER_STATUS, `TWRP_CODE_READ, 8'h00, 16, 5, 1'b1, rd);
    check("status read", {7'h00, rd[0]}, 8'h01);
    host.frame(6'h3f, `TWRP_CODE_READ, 8'h00, 16, 5, 1'b1, rd);
    check("unmapped", rd, `TWRP_UNMAPPED_READ);
    adapterDetectIn = 1'b0;
    repeat (8) @(negedge ref_clk);
    check("absent", {evtCount[6:0], adapterPresent}, 8'h04);
  endtask : t_adapter
  // External reset clears without waiting for a clock edge
  task automatic t_ext_reset();
    @(negedge ref_clk);
    externalResetN = 1'b0;
    #1;
    check("ext reset", supply | {3'h0, batteryMonitorTrim}, 8'h00);
    @(negedge ref_clk);
    externalResetN = 1'b1;
    repeat (4) @(negedge ref_clk);
    // The port must take a whole frame again once the reset is gone
    host.frame(`TWRP_OFFS_BATMON_TRIM, `TWRP_CODE_WRITE, 8'h0a, 16, 5, 1'b1, rd);
    check("trim after reset", {3'h0, batteryMonitorTrim}, 8'h0a);
  endtask : t_ext_reset
  initial
  begin
    sys_rst = 1'b1;
    externalResetN = 1'b1;
    adapterDetectIn = 1'b0;
    oeSeen = 1'b0;
    repeat (3) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge ref_clk);
    check("reset", supply | {2'h0, dataOe, batteryMonitorTrim}, 8'h00);
    t_write_read();
    t_refused();
    t_adapter();
    t_ext_reset();
    give_verdict();
  end
  initial
  begin
    #400000;
    err_count++;
    give_verdict();
  end
endmodule : twrp_register_port_tb
